// >>> logic/gwp_pkg.sv
// package: constants and types shared by the gated playback block
package gwp_pkg;
  localparam int NCH   = 2;
  localparam int AW    = 26;
  localparam int DW    = 16;
  localparam int LW    = 20;
  localparam int PWW   = 16;
  localparam int NSEG  = 16;
  localparam int NSTEP = 16;
  localparam int NADV  = 4;

  // working memory per channel: 32M standard, 64M option
  localparam logic [AW:0]    MEM_STD  = 27'h2000000;
  localparam logic [AW:0]    MEM_OPT  = 27'h4000000;
  localparam logic [LW-1:0]  LOOP_MIN = 20'h00001;
  localparam logic [LW-1:0]  LOOP_MAX = 20'hf4240;
  localparam logic [PWW-1:0] PWMIN_RST = 16'h0000;
  localparam logic [PWW-1:0] PWMAX_RST = 16'hffff;
  localparam logic [DW-1:0]  IDLE_RST  = 16'h0000;

  // byte offsets; channel 1 sits OFF_CH_STRIDE above channel 0
  localparam logic [11:0] OFF_CFG       = 12'h000;
  localparam logic [11:0] OFF_LOOPS     = 12'h004;
  localparam logic [11:0] OFF_IDLE      = 12'h008;
  localparam logic [11:0] OFF_SEGSEL    = 12'h00c;
  localparam logic [11:0] OFF_STAT      = 12'h010;
  localparam logic [11:0] OFF_SEGSTART  = 12'h040;
  localparam logic [11:0] OFF_SEGLEN    = 12'h080;
  localparam logic [11:0] OFF_STEP      = 12'h0c0;
  localparam logic [11:0] OFF_ADV       = 12'h100;
  localparam logic [11:0] OFF_CH_STRIDE = 12'h200;
  localparam logic [11:0] OFF_GCTRL     = 12'h400;
  localparam logic [11:0] OFF_CMD       = 12'h404;
  localparam logic [11:0] OFF_PWMIN     = 12'h408;
  localparam logic [11:0] OFF_PWMAX     = 12'h40c;

  // command register bit positions
  localparam int CMD_ABORT = 0;
  localparam int CMD_REARM = 2;
  localparam int CMD_JUMP  = 4;

  typedef enum logic [2:0] {OT_STD = 3'h0, OT_ARB = 3'h1, OT_SEQ = 3'h2, OT_ADV = 3'h3,
                            OT_MOD = 3'h4, OT_PULSE = 3'h5} out_type_t;
  typedef enum logic [1:0] {ADV_AUTO = 2'h0, ADV_ONCE = 2'h1, ADV_STEP = 2'h2} adv_mode_t;
  typedef enum logic [1:0] {SRC_TRIG = 2'h0, SRC_EVENT = 2'h1, SRC_BUS = 2'h2} src_t;
  typedef enum logic [1:0] {EDGE_RISE = 2'h0, EDGE_FALL = 2'h1, EDGE_BOTH = 2'h2} edge_t;
  typedef enum logic [1:0] {PW_OFF = 2'h0, PW_WIDER = 2'h1, PW_NARROWER = 2'h2,
                            PW_BETWEEN = 2'h3} pw_mode_t;
  typedef enum logic [4:0] {S_WAIT = 5'b00001, S_PLAY = 5'b00010, S_DWELL = 5'b00100,
                            S_HOLD = 5'b01000, S_STOP = 5'b10000} pb_state_t;

  typedef struct packed {
    logic [3:0] seq_last;
    adv_mode_t  amode;
    out_type_t  otype;
    logic       armed;
    logic       gated;
  } ch_cfg_t;
  localparam ch_cfg_t CFG_RST = '{4'h0, ADV_AUTO, OT_ARB, 1'h1, 1'h1};

  typedef struct packed {
    logic     common_clk;
    logic     sync_en;
    pw_mode_t pw_mode;
    edge_t    event_edge;
    edge_t    trig_edge;
    src_t     jump_src;
    src_t     init_src;
    logic     gate_level;
  } gctrl_t;
  localparam gctrl_t GCTRL_RST = '{1'h0, 1'h0, PW_OFF, EDGE_RISE, EDGE_RISE,
                                   SRC_EVENT, SRC_TRIG, 1'h1};

  typedef struct packed {
    logic          jump;
    logic [3:0]    seg;
    logic [LW-1:0] loops;
  } step_t;

  typedef struct packed {
    logic [3:0]    last;
    logic [3:0]    first;
    logic [LW-1:0] loops;
  } adv_t;

  typedef struct packed {
    logic      gate;
    logic [1:0] adv;
    logic [3:0] step;
    pb_state_t state;
  } stat_t;
endpackage

// >>> logic/edge_qualifier.sv
// input conditioner: synchroniser, edge select and pulse-width check
`timescale 1ns/100ps
module edge_qualifier
  import gwp_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           pin,
  input  wire edge_t          edge_sel,
  input  wire pw_mode_t       pw_mode,
  input  wire logic [PWW-1:0] pw_min,
  input  wire logic [PWW-1:0] pw_max,
  output logic                level,
  output logic                evt
);
  logic [2:0]     sync_reg;
  logic           level_reg;
  logic [PWW-1:0] width_reg;
  logic           evt_reg;
  logic           change;
  logic           act_hi;
  logic           edge_hit;
  logic           trail;

  function automatic logic width_ok(input pw_mode_t m, input logic [PWW-1:0] w,
                                    input logic [PWW-1:0] lo, input logic [PWW-1:0] hi);
    unique case (m)
      PW_OFF:      return 1'h1;
      PW_WIDER:    return w > lo;
      PW_NARROWER: return w < hi;
      PW_BETWEEN:  return (w > lo) && (w < hi);
    endcase
  endfunction

  // stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
  assign change   = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != level_reg);
  assign act_hi   = (edge_sel != EDGE_FALL);
  assign edge_hit = change && ((edge_sel == EDGE_BOTH) || (sync_reg[2] == act_hi));
  assign trail    = change && (level_reg == act_hi);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_reg <= 3'h0;
    else
      sync_reg <= {sync_reg[1:0], pin};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level_reg <= 1'h0;
    else if (change)
      level_reg <= sync_reg[2];
  end

  // saturates so a very long pulse still compares as wide
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      width_reg <= '0;
    else if (change)
      width_reg <= '0;
    else if (width_reg != '1)
      width_reg <= width_reg + 1'h1;
  end

  // a qualified pulse is judged at its trailing edge, once its width is known
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_reg <= 1'h0;
    else if (pw_mode == PW_OFF)
      evt_reg <= edge_hit;
    else
      evt_reg <= trail && width_ok(pw_mode, width_reg, pw_min, pw_max);
  end

  assign level = level_reg;
  assign evt   = evt_reg;
endmodule

// >>> logic/gated_playback.sv
// gated playback control: apb registers, gate, sequencer and sample feed
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module gated_playback
  import gwp_pkg::*;
#(
  parameter bit LARGE_MEM = 1'h0
)
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   trig_pin,
  input  wire logic                   event_pin,
  output logic [NCH-1:0][AW-1:0]      mem_addr,
  input  wire logic [NCH-1:0][DW-1:0] mem_rdata,
  output logic [NCH-1:0][DW-1:0]      dac_data,
  output logic [NCH-1:0]              running
);
  localparam logic [AW:0]   MEM_LIMIT = LARGE_MEM ? MEM_OPT : MEM_STD;
  localparam logic [AW-1:0] ADDR_MASK = AW'(MEM_LIMIT - 1'h1);

  ch_cfg_t        cfg_reg [NCH];
  logic [LW-1:0]  wloops_reg [NCH];
  logic [DW-1:0]  idle_reg [NCH];
  logic [3:0]     segsel_reg [NCH];
  gctrl_t         gctrl_reg;
  logic [PWW-1:0] pwmin_reg;
  logic [PWW-1:0] pwmax_reg;
  logic [AW-1:0]  seg_start_tab [NCH][NSEG];
  logic [AW-1:0]  seg_len_tab [NCH][NSEG];
  step_t          step_tab [NCH][NSTEP];
  adv_t           adv_tab [NCH][NADV];
  logic [31:0]    prdata_reg;
  logic [31:0]    rd_data;
  logic           bad;
  logic           wr_en;
  logic           glob;
  logic           ch_sel;
  logic [8:0]     loc;
  logic [3:0]     idx;
  logic           cmd_hit;
  logic [NCH-1:0] abort_cmd;
  logic [NCH-1:0] rearm_cmd;
  logic           jump_cmd;
  stat_t          stat_w [NCH];
  logic [NCH-1:0] wait_w;
  logic           trg_lvl;
  logic           trg_evt;
  logic           ev_lvl;
  logic           ev_evt;
  logic           init_lvl;
  logic           init_evt;
  logic           jump_evt;
  logic           gate_open_reg;
  logic           gate_d_reg;
  logic           gate_on;
  logic           gate_rise;

  function automatic logic [LW-1:0] loops_of(input logic [LW-1:0] x);
    if (x == '0)
      return LOOP_MIN;
    else if (x > LOOP_MAX)
      return LOOP_MAX;
    else
      return x;
  endfunction

  // ---------------- register bus ----------------
  assign glob    = (paddr[11:10] == OFF_GCTRL[11:10]);
  assign ch_sel  = paddr[9];
  assign loc     = paddr[8:0];
  assign idx     = paddr[5:2];
  assign wr_en   = psel && penable && pwrite && !bad;
  assign pready  = 1'h1;
  assign pslverr = psel && penable && bad;
  assign prdata  = prdata_reg;

  always_comb
  begin
    rd_data = '0;
    bad     = 1'h0;
    if ((paddr[1:0] != 2'h0) || paddr[11])
      bad = 1'h1;
    else if (glob)
    begin
      case (paddr[9:0])
        OFF_GCTRL[9:0]: rd_data = 32'(gctrl_reg);
        OFF_CMD[9:0]:   rd_data = '0;
        OFF_PWMIN[9:0]: rd_data = 32'(pwmin_reg);
        OFF_PWMAX[9:0]: rd_data = 32'(pwmax_reg);
        default:        bad = 1'h1;
      endcase
    end
    else
    begin
      case (loc[8:6])
        OFF_CFG[8:6]:
          case (loc)
            OFF_CFG[8:0]:    rd_data = 32'(cfg_reg[ch_sel]);
            OFF_LOOPS[8:0]:  rd_data = 32'(wloops_reg[ch_sel]);
            OFF_IDLE[8:0]:   rd_data = 32'(idle_reg[ch_sel]);
            OFF_SEGSEL[8:0]: rd_data = 32'(segsel_reg[ch_sel]);
            OFF_STAT[8:0]:   rd_data = 32'(stat_w[ch_sel]);
            default:         bad = 1'h1;
          endcase
        OFF_SEGSTART[8:6]: rd_data = 32'(seg_start_tab[ch_sel][idx]);
        OFF_SEGLEN[8:6]:   rd_data = 32'(seg_len_tab[ch_sel][idx]);
        OFF_STEP[8:6]:     rd_data = 32'(step_tab[ch_sel][idx]);
        OFF_ADV[8:6]:
          if (loc[5:4] == 2'h0)
            rd_data = 32'(adv_tab[ch_sel][idx[1:0]]);
          else
            bad = 1'h1;
        default: bad = 1'h1;
      endcase
    end
  end

  // read data is captured in the setup phase so the zero-wait access sees a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= '0;
    else if (psel && !penable)
      prdata_reg <= rd_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gctrl_reg <= GCTRL_RST;
      pwmin_reg <= PWMIN_RST;
      pwmax_reg <= PWMAX_RST;
      for (int i = 0; i < NCH; i++)
      begin
        cfg_reg[i]    <= CFG_RST;
        wloops_reg[i] <= LOOP_MIN;
        idle_reg[i]   <= IDLE_RST;
        segsel_reg[i] <= 4'h0;
      end
    end
    else if (wr_en && glob)
    begin
      case (paddr[9:0])
        OFF_GCTRL[9:0]: gctrl_reg <= gctrl_t'(pwdata[$bits(gctrl_t)-1:0]);
        OFF_PWMIN[9:0]: pwmin_reg <= pwdata[PWW-1:0];
        OFF_PWMAX[9:0]: pwmax_reg <= pwdata[PWW-1:0];
        default: ;
      endcase
    end
    else if (wr_en)
    begin
      case (loc)
        OFF_CFG[8:0]:    cfg_reg[ch_sel] <= ch_cfg_t'(pwdata[$bits(ch_cfg_t)-1:0]);
        OFF_LOOPS[8:0]:  wloops_reg[ch_sel] <= loops_of(pwdata[LW-1:0]);
        OFF_IDLE[8:0]:   idle_reg[ch_sel] <= pwdata[DW-1:0];
        OFF_SEGSEL[8:0]: segsel_reg[ch_sel] <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // tables hold waveform data only, so they carry no reset
  always_ff @(posedge pclk)
  begin
    if (wr_en && !glob)
    begin
      if (loc[8:6] == OFF_SEGSTART[8:6])
        seg_start_tab[ch_sel][idx] <= pwdata[AW-1:0];
      if (loc[8:6] == OFF_SEGLEN[8:6])
        seg_len_tab[ch_sel][idx] <= pwdata[AW-1:0];
      if (loc[8:6] == OFF_STEP[8:6])
        step_tab[ch_sel][idx] <= step_t'(pwdata[$bits(step_t)-1:0]);
      if ((loc[8:6] == OFF_ADV[8:6]) && (loc[5:4] == 2'h0))
        adv_tab[ch_sel][idx[1:0]] <= adv_t'(pwdata[$bits(adv_t)-1:0]);
    end
  end

  assign cmd_hit  = wr_en && glob && (paddr[9:0] == OFF_CMD[9:0]);
  assign jump_cmd = cmd_hit && pwdata[CMD_JUMP];

  // ---------------- gate ----------------
  edge_qualifier u_trig (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin      (trig_pin),
    .edge_sel (gctrl_reg.trig_edge),
    .pw_mode  (gctrl_reg.pw_mode),
    .pw_min   (pwmin_reg),
    .pw_max   (pwmax_reg),
    .level    (trg_lvl),
    .evt      (trg_evt)
  );

  // width qualification is a trigger-input feature; the event input never uses it
  edge_qualifier u_event (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin      (event_pin),
    .edge_sel (gctrl_reg.event_edge),
    .pw_mode  (PW_OFF),
    .pw_min   (pwmin_reg),
    .pw_max   (pwmax_reg),
    .level    (ev_lvl),
    .evt      (ev_evt)
  );

  assign init_lvl = (gctrl_reg.init_src == SRC_EVENT) ? ev_lvl : trg_lvl;
  assign init_evt = (gctrl_reg.init_src == SRC_EVENT) ? ev_evt : trg_evt;

  always_comb
  begin
    unique case (gctrl_reg.jump_src)
      SRC_TRIG:  jump_evt = trg_evt;
      SRC_EVENT: jump_evt = ev_evt;
      SRC_BUS:   jump_evt = jump_cmd;
      default:   jump_evt = 1'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_open_reg <= 1'h0;
    else if (init_evt)
      gate_open_reg <= !gate_open_reg;
  end

  // with width qualification the level is past its pulse when the gate opens
  assign gate_on = gate_open_reg &&
                   ((gctrl_reg.pw_mode != PW_OFF) || (init_lvl == gctrl_reg.gate_level));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_d_reg <= 1'h0;
    else
      gate_d_reg <= gate_on;
  end

  assign gate_rise = gate_on && !gate_d_reg;

  // ---------------- channels ----------------
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    ch_cfg_t       ecfg;
    pb_state_t     state_reg;
    pb_state_t     state_next;
    logic [AW-1:0] addr_reg;
    logic [AW-1:0] start_reg;
    logic [AW-1:0] end_reg;
    logic [LW-1:0] wcnt_reg;
    logic [LW-1:0] scnt_reg;
    logic [LW-1:0] scnt_next;
    logic [3:0]    stidx_reg;
    logic [1:0]    advidx_reg;
    logic [1:0]    advidx_next;
    logic          play_d_reg;
    logic [DW-1:0] dac_reg;
    logic          gated;
    logic          armed;
    logic          is_seq;
    logic          gate_lost;
    logic          start;
    logic          seg_end;
    logic          dwell;
    logic          do_adv;
    logic          seq_over;
    logic          load;
    logic [3:0]    first_idx;
    logic [3:0]    last_idx;
    logic [3:0]    nstep;
    logic [3:0]    tgt_step;
    logic [3:0]    tgt_seg;
    logic [AW-1:0] tgt_start;
    logic [AW-1:0] tgt_len;
    logic [AW-1:0] tgt_end;
    logic [LW-1:0] tgt_loops;

    always_comb
    begin
      ecfg = cfg_reg[c];
      if (gctrl_reg.common_clk)
      begin
        ecfg.gated = cfg_reg[0].gated;
        ecfg.armed = cfg_reg[0].armed;
      end
    end

    assign gated     = ecfg.gated;
    assign armed     = ecfg.armed || ecfg.gated;
    assign is_seq    = (ecfg.otype == OT_SEQ) || (ecfg.otype == OT_ADV);
    assign gate_lost = gated && !gate_on;
    // gated start is taken straight from the gate edge: no delay or retrigger path
    assign start = (state_reg == S_WAIT) && (!gctrl_reg.sync_en || (&wait_w)) &&
                   (!armed || (gated ? gate_rise : init_evt));
    assign seg_end   = (addr_reg == end_reg) && (wcnt_reg <= LOOP_MIN);
    assign dwell     = (ecfg.amode == ADV_STEP) || step_tab[c][stidx_reg].jump;
    assign do_adv    = !gate_lost && is_seq && !abort_cmd[c] &&
                       (((state_reg == S_PLAY) && seg_end && !dwell) ||
                        ((state_reg == S_DWELL) && jump_evt));
    assign first_idx = (ecfg.otype == OT_ADV) ? adv_tab[c][advidx_reg].first : 4'h0;
    assign last_idx  = (ecfg.otype == OT_ADV) ? adv_tab[c][advidx_reg].last : ecfg.seq_last;

    always_comb
    begin
      nstep       = stidx_reg + 4'h1;
      advidx_next = advidx_reg;
      scnt_next   = scnt_reg;
      seq_over    = 1'h0;
      if (stidx_reg == last_idx)
      begin
        nstep = first_idx;
        if ((ecfg.otype == OT_ADV) && (scnt_reg > LOOP_MIN))
          scnt_next = scnt_reg - LOOP_MIN;
        else if (ecfg.amode == ADV_ONCE)
          seq_over = 1'h1;
        else if (ecfg.otype == OT_ADV)
        begin
          advidx_next = advidx_reg + 2'h1;
          nstep       = adv_tab[c][advidx_next].first;
          scnt_next   = loops_of(adv_tab[c][advidx_next].loops);
        end
      end
    end

    assign tgt_step  = start ? ((ecfg.otype == OT_ADV) ? adv_tab[c][0].first : 4'h0) : nstep;
    assign tgt_seg   = is_seq ? step_tab[c][tgt_step].seg : segsel_reg[c];
    assign tgt_loops = loops_of(is_seq ? step_tab[c][tgt_step].loops : wloops_reg[c]);
    assign tgt_start = seg_start_tab[c][tgt_seg] & ADDR_MASK;
    assign tgt_len   = seg_len_tab[c][tgt_seg];
    assign tgt_end   = (tgt_len == '0) ? tgt_start : ((tgt_start + tgt_len - 1'h1) & ADDR_MASK);
    assign load      = start || (do_adv && !seq_over);

    always_comb
    begin
      state_next = state_reg;
      unique case (state_reg)
        S_STOP:
          if (rearm_cmd[c])
            state_next = S_WAIT;
        S_WAIT:
          if (start)
            state_next = S_PLAY;
        S_PLAY:
          if (gate_lost)
            state_next = S_WAIT;
          else if (seg_end && !is_seq)
            state_next = S_HOLD;
          else if (seg_end && dwell)
            state_next = S_DWELL;
          else if (do_adv && seq_over)
            state_next = S_HOLD;
        S_DWELL:
          if (gate_lost)
            state_next = S_WAIT;
          else if (do_adv && seq_over)
            state_next = S_HOLD;
          else if (do_adv)
            state_next = S_PLAY;
        S_HOLD:
          if (gate_lost)
            state_next = S_WAIT;
        default:
          state_next = S_WAIT;
      endcase
      if (abort_cmd[c])
        state_next = S_STOP;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        state_reg <= S_WAIT;
      else
        state_reg <= state_next;
    end

    // sample address walk; wraps at the end of the fitted working memory
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        addr_reg  <= '0;
        start_reg <= '0;
        end_reg   <= '0;
        wcnt_reg  <= LOOP_MIN;
      end
      else if (load && !abort_cmd[c])
      begin
        addr_reg  <= tgt_start;
        start_reg <= tgt_start;
        end_reg   <= tgt_end;
        wcnt_reg  <= tgt_loops;
      end
      else if ((state_reg == S_PLAY) && !gate_lost)
      begin
        if (addr_reg != end_reg)
          addr_reg <= (addr_reg + 1'h1) & ADDR_MASK;
        else if (wcnt_reg > LOOP_MIN)
        begin
          wcnt_reg <= wcnt_reg - LOOP_MIN;
          addr_reg <= start_reg;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        stidx_reg  <= 4'h0;
        advidx_reg <= 2'h0;
        scnt_reg   <= LOOP_MIN;
      end
      else if (start && !abort_cmd[c])
      begin
        stidx_reg  <= tgt_step;
        advidx_reg <= 2'h0;
        scnt_reg   <= loops_of(adv_tab[c][0].loops);
      end
      else if (do_adv)
      begin
        stidx_reg  <= tgt_step;
        advidx_reg <= advidx_next;
        scnt_reg   <= scnt_next;
      end
    end

    // memory answers one cycle after the address, so the play flag is delayed to match
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        play_d_reg <= 1'h0;
        dac_reg    <= IDLE_RST;
      end
      else
      begin
        play_d_reg <= (state_reg == S_PLAY);
        dac_reg    <= play_d_reg ? mem_rdata[c] : idle_reg[c];
      end
    end

    assign abort_cmd[c] = cmd_hit && pwdata[CMD_ABORT + c];
    assign rearm_cmd[c] = cmd_hit && pwdata[CMD_REARM + c];
    assign wait_w[c]    = (state_reg == S_WAIT);
    assign stat_w[c]    = '{gate_on, advidx_reg, stidx_reg, state_reg};
    assign mem_addr[c]  = addr_reg;
    assign dac_data[c]  = dac_reg;
    assign running[c]   = (state_reg == S_PLAY);
  end
endmodule

// >>> bench/gwp_monitor.sv
// checker: port-level relations of the gated playback block
`timescale 1ns/100ps
module gwp_monitor
  import gwp_pkg::*;
#(
  parameter bit LARGE_MEM = 1'h0
)
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  input wire logic                   trig_pin,
  input wire logic                   event_pin,
  input wire logic [NCH-1:0][AW-1:0] mem_addr,
  input wire logic [NCH-1:0][DW-1:0] mem_rdata,
  input wire logic [NCH-1:0][DW-1:0] dac_data,
  input wire logic [NCH-1:0]         running
);
  logic [1:0] pin_q;
  logic [3:0] since;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since either pin last moved; a start with no recent cause is a fault
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pin_q <= 2'h0;
      since <= 4'hf;
    end
    else
    begin
      pin_q <= {trig_pin, event_pin};
      since <= ({trig_pin, event_pin} != pin_q) ? 4'h0 : since + 4'(since != 4'hf);
    end
  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("access cycle without ready");
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("error response outside access cycle");
  AST_MISALIGN: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  AST_ERR_READ: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_ABORT: assert property (psel && penable && pwrite && paddr == OFF_CMD &&
    pwdata[CMD_ABORT] |-> ##1 !running[0] [*4]) else $error("abort did not stop output");
  AST_FEED: assert property ($past(running[0], 2) |-> dac_data[0] == $past(mem_rdata[0]))
    else $error("converter sample does not follow memory");
  AST_MEM: assert property ({1'h0, mem_addr[0]} < (LARGE_MEM ? MEM_OPT : MEM_STD))
    else $error("sample address beyond working memory");
  AST_START: assert property ($rose(running[0]) |-> since inside {[4'h1:4'h9]})
    else $error("output started without a gate transition");
endmodule

// >>> bench/sample_mem_model.sv
// far side model: sample memory with one cycle read latency
`timescale 1ns/100ps
module sample_mem_model
  import gwp_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic [NCH-1:0][AW-1:0] mem_addr,
  output logic      [NCH-1:0][DW-1:0] mem_rdata
);
  initial mem_rdata = '0;
  // pattern differs per channel and address so a stale word shows
  always @(posedge pclk)
    for (int c = 0; c < NCH; c++)
      mem_rdata[c] <= mem_addr[c][DW-1:0] ^ DW'(16'ha5c3 + c);
endmodule

// >>> bench/gated_waveform_playback_control_bench.sv
// testbench: registers, gated bursts and bus abort of the playback block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module gated_waveform_playback_control_bench
  import gwp_pkg::*;
;
  typedef struct {string nm; logic [31:0] v; logic [31:0] m;} note_t;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                   trig_pin, event_pin, probe;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, pv, a0, st, idle;
  logic [NCH-1:0][AW-1:0] mem_addr;
  logic [NCH-1:0][DW-1:0] mem_rdata, dac_data;
  logic [NCH-1:0]         running;
  int                     n_mismatch, n_compared, cycles, n, t, k;
  note_t                  q[$];
  note_t                  e;
  gated_playback dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .trig_pin(trig_pin), .event_pin(event_pin), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .dac_data(dac_data), .running(running));
  sample_mem_model mem_u (.pclk(pclk), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
  initial
  begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] ex,
                    input logic [31:0] m);
    q.push_back('{nm, ex, m});
    apb(1'h0, a, 32'h0);
  endtask
  task automatic look(input string nm, input logic [31:0] ex, input logic [31:0] got);
    q.push_back('{nm, ex, 32'hffffffff});
    pv <= got;
    probe <= 1'h1;
    @(posedge pclk);
    probe <= 1'h0;
    @(posedge pclk);
  endtask
  // waits for output to start, then counts how long it keeps running
  task automatic burst(output int len, output logic [31:0] first);
    for (t = 0; t < 40 && running[0] !== 1'h1; t++) @(negedge pclk);
    first = 32'(mem_addr[0]);
    for (len = 0; len < 100 && running[0] === 1'h1; len++) @(negedge pclk);
    @(posedge pclk);
  endtask
  always @(posedge pclk)
    if (probe || (psel && penable && pready && !pwrite))
    begin
      e = q.pop_front();
      `CHK(e.nm, e.v, (probe ? pv : prdata) & e.m)
    end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, trig_pin, event_pin, probe} = 7'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pv = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    k = $urandom(32'h52fd1a5f);
    rd("cfg", OFF_CFG, 32'(CFG_RST), '1);
    rd("gctrl", OFF_GCTRL, 32'(GCTRL_RST), '1);
    rd("pwmax", OFF_PWMAX, 32'(PWMAX_RST), '1);
    rd("hole", 12'h014, 32'h0, '1);
    rd("misaligned", 12'h002, 32'h0, '1);
    apb(1'h1, OFF_LOOPS, 32'h0);
    rd("loops min", OFF_LOOPS, 32'(LOOP_MIN), '1);
    apb(1'h1, OFF_LOOPS, 32'hfffff);
    rd("loops max", OFF_LOOPS, 32'(LOOP_MAX), '1);
    $display("test registers done");
    st = $urandom_range(32'h1ffffff, 0) & 32'h1fffff0;
    idle = $urandom_range(32'hffff, 0);
    apb(1'h1, OFF_SEGSTART, st);
    apb(1'h1, OFF_SEGLEN, 32'h4);
    apb(1'h1, OFF_LOOPS, 32'h2);
    apb(1'h1, OFF_IDLE, idle);
    apb(1'h1, OFF_GCTRL, 32'(GCTRL_RST) | 32'h40);
    for (k = 0; k < 2; k++)
    begin
      repeat (10) @(posedge pclk);
      look("idle level", idle, 32'(dac_data[0]));
      trig_pin <= 1'h1;
      burst(n, a0);
      look("first address", st, a0);
      look("burst length", 32'h8, 32'(n));
      trig_pin <= 1'h0;
    end
    repeat (10) @(posedge pclk);
    look("closed level", idle, 32'(dac_data[0]));
    $display("test gated burst done");
    apb(1'h1, OFF_LOOPS, 32'hfffff);
    trig_pin <= 1'h1;
    burst(n, a0);
    look("long burst", 32'd100, 32'(n));
    apb(1'h1, OFF_CMD, 32'h1 << CMD_ABORT);
    rd("stat stop", OFF_STAT, 32'(S_STOP), 32'h1f);
    for (k = 0; k < 3; k++)
    begin
      trig_pin <= ~trig_pin;
      repeat (8) @(posedge pclk);
      look("stopped", 32'h0, 32'(running[0]));
    end
    apb(1'h1, OFF_CMD, 32'h1 << CMD_REARM);
    rd("stat wait", OFF_STAT, 32'(S_WAIT), 32'h1f);
    apb(1'h1, OFF_CFG, 32'h0000000b);
    apb(1'h1, OFF_STEP, 32'h01000001);
    trig_pin <= 1'h1;
    burst(n, a0);
    rd("stat dwell", OFF_STAT, 32'(S_DWELL), 32'h1f);
    event_pin <= 1'h1;
    burst(n, a0);
    look("jump burst", 32'h4, 32'(n));
    $display("test abort and jump done");
    repeat (2) @(posedge pclk);
    finish_test();
  end
endmodule
bind gated_playback gwp_monitor #(.LARGE_MEM(LARGE_MEM)) mon_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .trig_pin(trig_pin),
  .event_pin(event_pin), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .dac_data(dac_data),
  .running(running));
